// file: rtl/mac_table_pkg.sv
package mac_table_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h41c;
  localparam logic [11:0] WORD1_OFS  = 12'h420;
  localparam logic [11:0] WORD2_OFS  = 12'h424;
  localparam logic [11:0] WORD3_OFS  = 12'h428;
  localparam logic [11:0] WORD4_OFS  = 12'h42c;
  localparam int          ADDR_W     = 12;
  // control register fields
  localparam int CTRL_GO_BIT     = 0;
  localparam int CTRL_ACTION_BIT = 1;
  localparam int CTRL_SELECT_BIT = 2;
  localparam int CTRL_INDEX_LO   = 8;
  localparam int INDEX_W         = 6;
  localparam int STATIC_INDEX_W  = 4;
  // entry word 1 fields
  localparam int W1_VALID_BIT    = 31;
  localparam int W1_SRC_DROP_BIT = 30;
  localparam int W1_DST_DROP_BIT = 29;
  localparam int W1_PRIO_LO      = 26;
  localparam int PRIO_W          = 3;
  localparam int SPAN_W          = 3;
  // entry word 2 fields
  localparam int W2_OVERRIDE_BIT = 31;
  localparam int W2_MULTICAST_GROUP_MATCH_ENABLE_BIT  = 30;
  localparam int PORT_W          = 3;
  // entry word 3 fields
  localparam int W3_FID_LO       = 16;
  localparam int FID_W           = 7;
  localparam int MAC_HI_W        = 16;
  // writable bits; others read as zero
  localparam logic [31:0] W1_MASK = 32'hfc00_0007;
  localparam logic [31:0] W2_MASK = 32'hc000_0007;
  localparam logic [31:0] W3_MASK = 32'h007f_ffff;
  localparam logic [31:0] W4_MASK = 32'hffff_ffff;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // table sizes
  localparam int STATIC_ENTRIES = 16;
  localparam int RSVD_ADDRS     = 48;
  localparam int RSVD_GROUPS    = 8;
  localparam int RSVD_GROUP_W   = 3;
  localparam int RSVD_LOW_W     = 6;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// file: rtl/mac_table_access.sv
`timescale 1ns/100ps
// Contract
// - sixteen host-programmed static entries, never aged
// - every lookup searches static and other tables
// - static hit beats any dynamic hit
// - four-bit index selects static entry
// - select bit: 0 static, 1 reserved multicast
// - action bit: 0 write, 1 read
// - go bit launches access, self-clears when done
// - read result lands in data words
// - source filter bit drops matching source
// - destination filter bit drops matching destination
// - word1 valid, filter, priority and spanning group bits, rest zero
// - word2 bit31 overrides port spanning state
// - word2 bit30 adds group id on multicast
// - word2 low bits are port forward mask
// - word3 group id and upper mac bits
// - word4 lower mac bits, reset zero
// - 48 reserved addresses, indexed by low six
// - reserved addresses share eight group masks
// - reserved access uses six-bit index, word2 mask
module mac_table_access #(
  parameter logic [47:0] RSVD_BASE = 48'h0000_0000_0000
) (
  // clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // ahb-lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic       [31:0] hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // lookup request
  input  wire  logic        lookup_req,
  input  wire  logic [47:0] destination_mac,
  input  wire  logic [47:0] source_mac,
  input  wire  logic [6:0]  lookup_fid,
  // dynamic table result, same cycle as request
  input  wire  logic        dyn_hit,
  input  wire  logic        dyn_static,
  input  wire  logic        dyn_drop,
  input  wire  logic [2:0]  dyn_ports,
  // lookup result
  output logic              lookup_done,
  output logic              static_hit,
  output logic              dest_drop,
  output logic              source_drop,
  output logic              state_override,
  output logic [2:0]        forward_ports,
  output logic [2:0]        fwd_priority,
  output logic [2:0]        spanning_group_id
);

  localparam int NE = mac_table_pkg::STATIC_ENTRIES;

  function automatic logic rsvd_in_range(input logic [5:0] idx);
    rsvd_in_range = 32'(idx) < mac_table_pkg::RSVD_ADDRS;
  endfunction

  // group of a reserved address: low three bits of the index
  function automatic logic [2:0] rsvd_group(input logic [5:0] idx);
    rsvd_group = idx[2:0];
  endfunction

  // bus state
  logic                    wr_pend_q;
  logic                    rd_pend_q;
  logic [11:0]             addr_q;
  logic                    accept;
  logic                    bus_wr;
  // access control
  logic                    go_done_bit_q;
  logic                    action_q;
  logic                    select_q;
  logic [5:0]              index_q;
  logic                    exec_write;
  logic                    exec_read;
  // data words
  logic [31:0]             w1_q;
  logic [31:0]             w2_q;
  logic [31:0]             w3_q;
  logic [31:0]             w4_q;
  // tables
  logic [31:0]             st_w1_q [NE];
  logic [31:0]             st_w2_q [NE];
  logic [31:0]             st_w3_q [NE];
  logic [31:0]             st_w4_q [NE];
  logic [2:0]              rsvd_q  [mac_table_pkg::RSVD_GROUPS];
  // lookup search
  logic                    st_hit;
  logic [3:0]              st_idx;
  logic                    src_hit;
  logic                    rsvd_hit;
  logic [31:0]             rd_mux;

  assign accept = hsel && hready && htrans == mac_table_pkg::HTRANS_NONSEQ;
  assign bus_wr = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      if (accept) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  always_comb begin
    case (addr_q)
      mac_table_pkg::CTRL_OFS: begin
        rd_mux = 32'h0000_0000;
        rd_mux[mac_table_pkg::CTRL_GO_BIT]     = go_done_bit_q;
        rd_mux[mac_table_pkg::CTRL_ACTION_BIT] = action_q;
        rd_mux[mac_table_pkg::CTRL_SELECT_BIT] = select_q;
        rd_mux[mac_table_pkg::CTRL_INDEX_LO +: mac_table_pkg::INDEX_W] =
          index_q;
      end
      mac_table_pkg::WORD1_OFS: rd_mux = w1_q;
      mac_table_pkg::WORD2_OFS: rd_mux = w2_q;
      mac_table_pkg::WORD3_OFS: rd_mux = w3_q;
      mac_table_pkg::WORD4_OFS: rd_mux = w4_q;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state on reads so a write just before is already stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (rd_pend_q) begin
      hreadyout <= 1'b1;
      hrdata    <= rd_mux;
    end
  end

  // control register; writes while busy are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_done_bit_q <= 1'b0;
      action_q      <= 1'b0;
      select_q      <= 1'b0;
      index_q       <= 6'h00;
    end else if (go_done_bit_q) begin
      go_done_bit_q <= 1'b0;
    end else if (bus_wr && addr_q == mac_table_pkg::CTRL_OFS) begin
      go_done_bit_q <= hwdata[mac_table_pkg::CTRL_GO_BIT];
      action_q      <= hwdata[mac_table_pkg::CTRL_ACTION_BIT];
      select_q      <= hwdata[mac_table_pkg::CTRL_SELECT_BIT];
      index_q       <= hwdata[mac_table_pkg::CTRL_INDEX_LO +:
                              mac_table_pkg::INDEX_W];
    end
  end

  assign exec_write = go_done_bit_q && !action_q;
  assign exec_read  = go_done_bit_q && action_q;

  // data words; a table read overrides a clashing bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w1_q <= mac_table_pkg::WORD_RESET;
      w2_q <= mac_table_pkg::WORD_RESET;
      w3_q <= mac_table_pkg::WORD_RESET;
      w4_q <= mac_table_pkg::WORD_RESET;
    end else if (exec_read && !select_q) begin
      w1_q <= st_w1_q[index_q[3:0]];
      w2_q <= st_w2_q[index_q[3:0]];
      w3_q <= st_w3_q[index_q[3:0]];
      w4_q <= st_w4_q[index_q[3:0]];
    end else if (exec_read) begin
      w2_q[2:0] <= rsvd_in_range(index_q) ?
                   rsvd_q[rsvd_group(index_q)] : 3'b000;
    end else if (bus_wr) begin
      case (addr_q)
        mac_table_pkg::WORD1_OFS: w1_q <= hwdata & mac_table_pkg::W1_MASK;
        mac_table_pkg::WORD2_OFS: w2_q <= hwdata & mac_table_pkg::W2_MASK;
        mac_table_pkg::WORD3_OFS: w3_q <= hwdata & mac_table_pkg::W3_MASK;
        mac_table_pkg::WORD4_OFS: w4_q <= hwdata & mac_table_pkg::W4_MASK;
        default: ;
      endcase
    end
  end

  // tables are written only by the host; nothing ever ages them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NE; i++) begin
        st_w1_q[i] <= mac_table_pkg::WORD_RESET;
        st_w2_q[i] <= mac_table_pkg::WORD_RESET;
        st_w3_q[i] <= mac_table_pkg::WORD_RESET;
        st_w4_q[i] <= mac_table_pkg::WORD_RESET;
      end
      for (int g = 0; g < mac_table_pkg::RSVD_GROUPS; g++) begin
        rsvd_q[g] <= 3'b000;
      end
    end else if (exec_write && !select_q) begin
      st_w1_q[index_q[3:0]] <= w1_q;
      st_w2_q[index_q[3:0]] <= w2_q;
      st_w3_q[index_q[3:0]] <= w3_q;
      st_w4_q[index_q[3:0]] <= w4_q;
    end else if (exec_write && rsvd_in_range(index_q)) begin
      rsvd_q[rsvd_group(index_q)] <= w2_q[2:0];
    end
  end

  // search: lowest matching valid entry wins
  always_comb begin
    logic        mac_eq;
    logic        fid_eq;
    logic [31:0] e1;
    logic [31:0] e2;
    logic [31:0] e3;
    logic [47:0] emac;
    mac_eq  = 1'b0;
    fid_eq  = 1'b0;
    e1      = 32'h0000_0000;
    e2      = 32'h0000_0000;
    e3      = 32'h0000_0000;
    emac    = 48'h0000_0000_0000;
    st_hit  = 1'b0;
    st_idx  = 4'h0;
    src_hit = 1'b0;
    for (int i = NE - 1; i >= 0; i--) begin
      e1     = st_w1_q[i];
      e2     = st_w2_q[i];
      e3     = st_w3_q[i];
      emac   = {e3[mac_table_pkg::MAC_HI_W-1:0], st_w4_q[i]};
      mac_eq = emac == destination_mac;
      fid_eq = !(destination_mac[40] && e2[mac_table_pkg::W2_MULTICAST_GROUP_MATCH_ENABLE_BIT])
               || e3[mac_table_pkg::W3_FID_LO +: mac_table_pkg::FID_W]
                  == lookup_fid;
      if (e1[mac_table_pkg::W1_VALID_BIT] && mac_eq && fid_eq) begin
        st_hit = 1'b1;
        st_idx = 4'(i);
      end
      if (e1[mac_table_pkg::W1_VALID_BIT] && emac == source_mac &&
          e1[mac_table_pkg::W1_SRC_DROP_BIT]) begin
        src_hit = 1'b1;
      end
    end
  end

  assign rsvd_hit = destination_mac[47:6] == RSVD_BASE[47:6] &&
                    rsvd_in_range(destination_mac[5:0]);

  // result; unknown destinations flood all ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lookup_done       <= 1'b0;
      static_hit        <= 1'b0;
      dest_drop         <= 1'b0;
      source_drop       <= 1'b0;
      state_override    <= 1'b0;
      forward_ports     <= 3'b000;
      fwd_priority      <= 3'b000;
      spanning_group_id <= 3'b000;
    end else begin
      lookup_done <= lookup_req;
      if (lookup_req) begin
        source_drop    <= src_hit;
        static_hit     <= st_hit || (dyn_hit && dyn_static);
        state_override <= 1'b0;
        fwd_priority   <= 3'b000;
        spanning_group_id <= 3'b000;
        if (st_hit) begin
          forward_ports  <=
            st_w2_q[st_idx][mac_table_pkg::PORT_W-1:0];
          dest_drop      <=
            st_w1_q[st_idx][mac_table_pkg::W1_DST_DROP_BIT];
          state_override <=
            st_w2_q[st_idx][mac_table_pkg::W2_OVERRIDE_BIT];
          fwd_priority   <= st_w1_q[st_idx][mac_table_pkg::W1_PRIO_LO +:
                                            mac_table_pkg::PRIO_W];
          spanning_group_id <= st_w1_q[st_idx][mac_table_pkg::SPAN_W-1:0];
        end else if (dyn_hit && dyn_static) begin
          forward_ports <= dyn_ports;
          dest_drop     <= dyn_drop;
        end else if (rsvd_hit) begin
          forward_ports <= rsvd_q[rsvd_group(destination_mac[5:0])];
          dest_drop     <= 1'b0;
        end else if (dyn_hit) begin
          forward_ports <= dyn_ports;
          dest_drop     <= dyn_drop;
        end else begin
          forward_ports <= 3'b111;
          dest_drop     <= 1'b0;
        end
      end
    end
  end

  // checks
  sequence s_launch;
    bus_wr && addr_q == mac_table_pkg::CTRL_OFS &&
    hwdata[mac_table_pkg::CTRL_GO_BIT] && !go_done_bit_q;
  endsequence
  sequence s_finish;
    go_done_bit_q ##1 !go_done_bit_q;
  endsequence

  property p_launch;
    @(posedge hclk) disable iff (!hresetn) s_launch |=> s_finish;
  endproperty
  a_launch: assert property (p_launch)
    else $error("go bit did not run one cycle then clear");

  property p_static_read;
    @(posedge hclk) disable iff (!hresetn)
      exec_read && !select_q |=>
      w4_q == $past(st_w4_q[index_q[3:0]]) &&
      w1_q == $past(st_w1_q[index_q[3:0]]);
  endproperty
  a_static_read: assert property (p_static_read)
    else $error("static read did not load data words");

  property p_static_write;
    @(posedge hclk) disable iff (!hresetn)
      exec_write && !select_q |=> st_w3_q[$past(index_q[3:0])] == $past(w3_q);
  endproperty
  a_static_write: assert property (p_static_write)
    else $error("static write missed the indexed entry");

  property p_rsvd_group;
    @(posedge hclk) disable iff (!hresetn)
      exec_write && select_q && rsvd_in_range(index_q) |=>
      rsvd_q[$past(index_q[2:0])] == $past(w2_q[2:0]);
  endproperty
  a_rsvd_group: assert property (p_rsvd_group)
    else $error("reserved group mask not updated");

  property p_static_wins;
    @(posedge hclk) disable iff (!hresetn)
      lookup_req && st_hit && dyn_hit |=>
      static_hit && forward_ports == $past(st_w2_q[st_idx][2:0]);
  endproperty
  a_static_wins: assert property (p_static_wins)
    else $error("dynamic result beat a static hit");

  property p_dst_drop;
    @(posedge hclk) disable iff (!hresetn)
      lookup_req && st_hit &&
      st_w1_q[st_idx][mac_table_pkg::W1_DST_DROP_BIT] |=> dest_drop;
  endproperty
  a_dst_drop: assert property (p_dst_drop)
    else $error("destination filter did not drop");

  property p_src_drop;
    @(posedge hclk) disable iff (!hresetn)
      lookup_req |=> source_drop == $past(src_hit) && lookup_done;
  endproperty
  a_src_drop: assert property (p_src_drop)
    else $error("source filter result wrong");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
      accept && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase not exactly one wait state");

endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } reg_row_t;
  typedef struct {
    logic [47:0] da;
    logic [47:0] sa;
    logic [6:0]  filter_group_id;
    logic [2:0]  dyn;
    logic [2:0]  dp;
    logic [5:0]  exp;
  } lk_row_t;

  localparam logic [47:0] MAC_A = 48'h0a0b_0c0d_0e0f;
  localparam logic [47:0] MAC_B = 48'h1122_3344_5566;
  localparam logic [47:0] MAC_C = 48'h0000_0000_0077;
  localparam logic [47:0] MAC_D = 48'h0100_0000_0001;
  localparam logic [47:0] MAC_E = 48'h0200_0000_0abc;
  localparam logic [47:0] MAC_R = 48'h0000_0000_0013;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        lookup_req;
  logic [47:0] destination_mac;
  logic [47:0] source_mac;
  logic [6:0]  lookup_fid;
  logic        dyn_hit;
  logic        dyn_static;
  logic        dyn_drop;
  logic [2:0]  dyn_ports;
  logic        lookup_done;
  logic        static_hit;
  logic        dest_drop;
  logic        source_drop;
  logic        state_override;
  logic [2:0]  forward_ports;
  logic [2:0]  fwd_priority;
  logic [2:0]  spanning_group_id;
  logic [31:0] rd;
  int          n_fail;
  int          cmp_count;
  int          cyc = 0;

  reg_row_t regs [7] = '{
    '{12'h420, 32'hffff_ffff, 32'hfc00_0007},
    '{12'h424, 32'hffff_ffff, 32'hc000_0007},
    '{12'h428, 32'hffff_ffff, 32'h007f_ffff},
    '{12'h42c, 32'hffff_ffff, 32'hffff_ffff},
    '{12'h430, 32'hffff_ffff, 32'h0000_0000},
    '{12'h420, 32'ha5a5_a5a5, 32'ha400_0005},
    '{12'h42c, 32'h1234_5678, 32'h1234_5678}};
  // exp is {ports, static hit, dest drop, source drop}
  lk_row_t lks [7] = '{
    '{MAC_A, MAC_E, 7'h00, 3'h6, 3'h2, 6'h2c},
    '{MAC_B, MAC_E, 7'h00, 3'h0, 3'h0, 6'h16},
    '{MAC_E, MAC_B, 7'h00, 3'h4, 3'h2, 6'h11},
    '{MAC_C, MAC_E, 7'h00, 3'h0, 3'h0, 6'h38},
    '{MAC_D, MAC_E, 7'h15, 3'h0, 3'h0, 6'h24},
    '{MAC_D, MAC_E, 7'h16, 3'h0, 3'h0, 6'h38},
    '{MAC_R, MAC_E, 7'h00, 3'h4, 3'h1, 6'h30}};

  mac_table_access mac_table_access_inst (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .lookup_req        (lookup_req),
    .destination_mac   (destination_mac),
    .source_mac        (source_mac),
    .lookup_fid        (lookup_fid),
    .dyn_hit           (dyn_hit),
    .dyn_static        (dyn_static),
    .dyn_drop          (dyn_drop),
    .dyn_ports         (dyn_ports),
    .lookup_done       (lookup_done),
    .static_hit        (static_hit),
    .dest_drop         (dest_drop),
    .source_drop       (source_drop),
    .state_override    (state_override),
    .forward_ports     (forward_ports),
    .fwd_priority      (fwd_priority),
    .spanning_group_id (spanning_group_id)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // generous ceiling; the whole sequence needs well under 2000 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task chk(input string what, input logic [47:0] seen,
           input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // entered just after a rising edge; read data lands in rd
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= mac_table_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, rd, e);
    chk({what, " resp"}, hresp, 1'b0);
  endtask

  task table_op(input logic sel, input logic act, input logic [5:0] idx);
    int n;
    n = 0;
    bus(1'b1, mac_table_pkg::CTRL_OFS,
        {18'h0, idx, 5'h0, sel, act, 1'b1});
    do begin
      bus(1'b0, mac_table_pkg::CTRL_OFS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk("go_done", rd[0], 1'b0);
  endtask

  task wr_entry(input logic [5:0] idx, input logic [31:0] w1,
                input logic [31:0] w2, input logic [31:0] w3,
                input logic [31:0] w4);
    // all four words before the start command
    bus(1'b1, mac_table_pkg::WORD1_OFS, w1);
    bus(1'b1, mac_table_pkg::WORD2_OFS, w2);
    bus(1'b1, mac_table_pkg::WORD3_OFS, w3);
    bus(1'b1, mac_table_pkg::WORD4_OFS, w4);
    table_op(1'b0, 1'b0, idx);
  endtask

  // data words are smeared first so a stale value cannot pass
  task rd_entry(input logic [5:0] idx, input logic [31:0] w1,
                input logic [31:0] w2, input logic [31:0] w3,
                input logic [31:0] w4);
    // words only, no start: a table write here would clobber an entry
    bus(1'b1, mac_table_pkg::WORD1_OFS, 32'hffff_ffff);
    bus(1'b1, mac_table_pkg::WORD2_OFS, 32'hffff_ffff);
    bus(1'b1, mac_table_pkg::WORD3_OFS, 32'hffff_ffff);
    bus(1'b1, mac_table_pkg::WORD4_OFS, 32'hffff_ffff);
    table_op(1'b0, 1'b1, idx);
    rdchk("entry word1", mac_table_pkg::WORD1_OFS, w1);
    rdchk("entry word2", mac_table_pkg::WORD2_OFS, w2);
    rdchk("entry word3", mac_table_pkg::WORD3_OFS, w3);
    rdchk("entry word4", mac_table_pkg::WORD4_OFS, w4);
  endtask

  task lookup(input lk_row_t r, input int i);
    destination_mac <= r.da;
    source_mac      <= r.sa;
    lookup_fid      <= r.filter_group_id;
    {dyn_hit, dyn_static, dyn_drop} <= r.dyn;
    dyn_ports       <= r.dp;
    lookup_req      <= 1'b1;
    @(posedge hclk);
    lookup_req <= 1'b0;
    #1;
    chk($sformatf("lookup done %0d", i), lookup_done, 1'b1);
    chk($sformatf("lookup %0d", i),
        {forward_ports, static_hit, dest_drop, source_drop},
        r.exp);
    @(posedge hclk);
  endtask

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {lookup_req, destination_mac, source_mac, lookup_fid} = '0;
    {dyn_hit, dyn_static, dyn_drop, dyn_ports} = '0;
    hsize     = 3'b010;
    hresetn   = 1'b0;
    n_fail    = 0;
    cmp_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("word4 reset", mac_table_pkg::WORD4_OFS, 32'h0);
    foreach (regs[i]) begin
      bus(1'b1, regs[i].a, regs[i].wd);
      rdchk($sformatf("reg row %0d", i), regs[i].a,
            regs[i].exp);
    end
    // index 15 is the top of the four-bit range
    wr_entry(6'd0, 32'h9400_0003, 32'h8000_0005, 32'h0000_0a0b,
             32'h0c0d_0e0f);
    wr_entry(6'd15, 32'he000_0000, 32'h0000_0002, 32'h0000_1122,
             32'h3344_5566);
    wr_entry(6'd5, 32'h1c00_0000, 32'h0000_0003, 32'h0, 32'h77);
    wr_entry(6'd7, 32'h8000_0000, 32'h4000_0004, 32'h0015_0100,
             32'h0000_0001);
    rd_entry(6'd15, 32'he000_0000, 32'h0000_0002, 32'h0000_1122,
             32'h3344_5566);
    rd_entry(6'd0, 32'h9400_0003, 32'h8000_0005, 32'h0000_0a0b,
             32'h0c0d_0e0f);
    // reserved index 3 and 11 share group storage
    bus(1'b1, mac_table_pkg::WORD2_OFS, 32'h6);
    table_op(1'b1, 1'b0, 6'd3);
    bus(1'b1, mac_table_pkg::WORD2_OFS, 32'h0);
    table_op(1'b1, 1'b1, 6'd11);
    bus(1'b0, mac_table_pkg::WORD2_OFS, 32'h0);
    chk("rsvd group mask", rd[2:0], 3'h6);
    bus(1'b1, mac_table_pkg::WORD2_OFS, 32'h1);
    table_op(1'b1, 1'b0, 6'd50);
    table_op(1'b1, 1'b1, 6'd2);
    bus(1'b0, mac_table_pkg::WORD2_OFS, 32'h0);
    chk("rsvd out of range", rd[2:0], 3'h0);
    foreach (lks[i]) begin
      lookup(lks[i], i);
      if (i == 0) begin
        chk("priority", fwd_priority, 3'd5);
        chk("span group", spanning_group_id, 3'd3);
        chk("override", state_override, 1'b1);
      end
    end
    // reset in mid-run clears words and tables
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("word4 rerun", mac_table_pkg::WORD4_OFS, 32'h0);
    lookup('{MAC_A, MAC_E, 7'h00, 3'h0, 3'h0, 6'h38}, 9);
    report_and_stop();
  end
endmodule
